// File: shared/monitor_pkg.sv
// constants, register map and state codes of the result and limit monitor
package monitor_pkg;
  // ----------------------------------------
  // register pointers
  // ----------------------------------------
  localparam logic [7:0] PTR_CMD = 8'h00;
  localparam logic [7:0] PTR_VRES = 8'h01;
  localparam logic [7:0] PTR_TRES = 8'h02;
  localparam logic [7:0] PTR_TAVG = 8'h03;
  localparam logic [7:0] PTR_LIM_BASE = 8'h04;
  localparam int LIM_STRIDE = 3;
  localparam int NUM_CH = 9;
  // ----------------------------------------
  // command register fields
  // ----------------------------------------
  localparam int CMD_AUTO = 0;
  localparam int CMD_RST = 1;
  localparam int CMD_CLR = 2;
  localparam int CMD_POL = 3;
  localparam int CMD_EXTREF = 4;
  localparam int CMD_QUIET = 5;
  localparam int CMD_SEL_LSB = 7;
  localparam logic [15:0] CMD_RESET = 16'h0000;
  // ----------------------------------------
  // channel tags and reset values
  // ----------------------------------------
  localparam logic [3:0] TAG_TEMP = 4'h8;
  localparam logic [3:0] TAG_TAVG = 4'h9;
  localparam logic [11:0] VUP_RESET = 12'hfff;
  localparam logic [11:0] VLO_RESET = 12'h000;
  localparam logic [11:0] TUP_RESET = 12'h7ff;
  localparam logic [11:0] TLO_RESET = 12'h800;
  localparam logic [11:0] HYS_RESET = 12'h000;
  localparam logic [15:0] RES_RESET = 16'h0000;
  localparam int AVG_SHIFT = 3;
  // slave address, arbitrary value
  localparam logic [6:0] DEV_ADDR = 7'h2f;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_NS = 10;
  localparam int GLITCH_NS = 50;
  localparam int GLITCH_CYC = (GLITCH_NS + CLK_NS - 1) / CLK_NS;
  localparam int TEMP_PERIOD_US = 5000;
  localparam int TEMP_CYC = (TEMP_PERIOD_US * 1000) / CLK_NS;
  // ----------------------------------------
  // serial slave states
  // ----------------------------------------
  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_ADDR = 6'b000010,
    ST_PTR = 6'b000100,
    ST_WHI = 6'b001000,
    ST_WLO = 6'b010000,
    ST_READ = 6'b100000
  } bus_state_t;
endpackage

// File: shared/monitor_if.sv
// conversion results, limits and alarm flags between monitor modules
`timescale 1ns/1ns
interface monitor_if;
  logic conv_valid;
  logic [3:0] conv_tag;
  logic [11:0] conv_data;
  logic [8:0][11:0] upper;
  logic [8:0][11:0] lower;
  logic [8:0][11:0] hyst;
  logic clear;
  logic [8:0] alarm;
  modport regs (output conv_valid, conv_tag, conv_data, upper, lower, hyst, clear,
    input alarm);
  modport check (input conv_valid, conv_tag, conv_data, upper, lower, hyst, clear,
    output alarm);
endinterface

// File: verilog/glitch_filter.sv
// two-stage synchroniser and short-pulse rejection for the serial pins
`timescale 1ns/1ns
module glitch_filter (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // raw and filtered pins
  input wire logic [1:0] raw_in,
  output logic [1:0] clean_out
);
  localparam logic [3:0] LAST = 4'(monitor_pkg::GLITCH_CYC - 1);

  genvar i;
  generate
    for (i = 0; i < 2; i++) begin : g_pin
      logic meta_q;
      logic sync_q;
      logic [3:0] cnt_q;
      // synchroniser, first stage read only by the second
      always_ff @(posedge clk_in) begin
        if (rst_in) begin
          meta_q <= 1'b1;
          sync_q <= 1'b1;
        end else begin
          meta_q <= raw_in[i];
          sync_q <= meta_q;
        end
      end
      // new level taken only after it stood the full glitch width
      always_ff @(posedge clk_in) begin
        if (rst_in) begin
          cnt_q <= 4'h0;
          clean_out[i] <= 1'b1;
        end else if (sync_q == clean_out[i]) begin
          cnt_q <= 4'h0;
        end else if (cnt_q == LAST) begin
          cnt_q <= 4'h0;
          clean_out[i] <= sync_q;
        end else begin
          cnt_q <= cnt_q + 4'h1;
        end
      end
    end
  endgenerate
endmodule // glitch_filter

// File: verilog/limit_checker.sv
// per-channel upper and lower limit compare with hysteresis
`timescale 1ns/1ns
module limit_checker (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // results, limits and alarms
  monitor_if.check mon
);
  genvar i;
  generate
    for (i = 0; i < monitor_pkg::NUM_CH; i++) begin : g_ch
      logic hi_q;
      logic lo_q;
      logic signed [13:0] res;
      logic signed [13:0] up;
      logic signed [13:0] lo;
      logic signed [13:0] n;
      logic hit;
      // temperature compares signed, voltages unsigned
      if (i == monitor_pkg::NUM_CH - 1) begin : g_signed
        assign res = 14'(signed'(mon.conv_data));
        assign up = 14'(signed'(mon.upper[i]));
        assign lo = 14'(signed'(mon.lower[i]));
      end else begin : g_unsigned
        assign res = {2'b00, mon.conv_data};
        assign up = {2'b00, mon.upper[i]};
        assign lo = {2'b00, mon.lower[i]};
      end
      assign n = {2'b00, mon.hyst[i]};
      assign hit = mon.conv_valid && (mon.conv_tag == 4'(i));
      // alarm flags, clear bit held high blocks them
      always_ff @(posedge clk_in) begin
        if (rst_in || mon.clear) begin
          hi_q <= 1'b0;
          lo_q <= 1'b0;
        end else if (hit) begin
          if (res > up) begin
            hi_q <= 1'b1;
          end else if (res + n <= up) begin
            hi_q <= 1'b0;
          end
          if (res < lo) begin
            lo_q <= 1'b1;
          end else if (res >= lo + n) begin
            lo_q <= 1'b0;
          end
        end
      end
      assign mon.alarm[i] = hi_q | lo_q;
    end
  endgenerate
endmodule // limit_checker

// File: verilog/adc_result_limit_monitor.sv
// serial register slave, result registers and alarm output of the monitor
`timescale 1ns/1ns
// Operation
// - quiet-sampling bit holds conversion steps during bus traffic; zero at reset.
// - temperature wait has no fixed time; result taken whenever it arrives.
// - pulses on serial pins shorter than 50 ns are ignored.
// - voltage result at pointer 1 is read-only straight binary.
// - results read as two bytes, high byte first then low byte.
// - result word holds channel tag in 15:12 and value in 11:0.
// - tags 0..7 for analog inputs, 8 temperature, 9 average.
// - temperature and average values kept in two's complement.
// - temperature result at pointer 2 is read-only with its tag.
// - temperature conversion requested every 5 ms, result register updated.
// - average at pointer 3 refreshed after every temperature conversion.
// - first average after enabling equals first raw temperature result.
// - nine channels each hold upper, lower and hysteresis twelve-bit registers.
// - upper limit bits 15:12 read zero; controller writes zeros there.
// - voltage upper limits reset full scale, lower limits zero scale.
// - temperature upper limit resets 0x7ff, lower limit 0x800.
// - alarm when a result is strictly above its upper limit.
// - upper alarm releases once result is N codes below limit.
// - clear bit in command register releases alarms regardless of hysteresis.
// - alarm below lower limit, released N codes above it.
// - clear bit erases alarm state; controller must write it back zero.
// - polarity bit one makes alarm active low; zero at reset.
// - hysteresis registers reset to zero.
module adc_result_limit_monitor #(
  parameter int TEMP_CYC = monitor_pkg::TEMP_CYC
) (
  // clock and reset
  input wire logic MCLK_IN,
  input wire logic RST_IN,
  // serial bus pins
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE_OUT,
  // converter core results
  input wire logic CONV_VALID_IN,
  input wire logic [3:0] CONV_TAG_IN,
  input wire logic [11:0] CONV_DATA_IN,
  // converter core control
  output logic TEMP_REQ_OUT,
  output logic HOLD_TRIALS_OUT,
  output logic [8:0] CHAN_SEL_OUT,
  output logic AUTOCYCLE_OUT,
  output logic EXT_REF_OUT,
  // alarm pin
  output logic ALERT_OUT
);
  // ----------------------------------------
  // declarations
  // ----------------------------------------
  monitor_if mon ();
  logic [1:0] clean;
  logic scl_prev_q;
  logic sda_prev_q;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  monitor_pkg::bus_state_t state_q;
  logic [3:0] bit_cnt_q;
  logic ack_phase_q;
  logic rd_mode_q;
  logic master_nack_q;
  logic [7:0] rx_q;
  logic [7:0] tx_q;
  logic [7:0] ptr_q;
  logic [7:0] wr_hi_q;
  logic [15:0] rd_word_q;
  logic bus_active_q;
  logic wr_stb;
  logic [15:0] wr_data;
  logic [15:0] rd_mux;
  logic [15:0] cmd_q;
  logic soft_rst_q;
  logic rst;
  logic [15:0] vres_q;
  logic [15:0] tres_q;
  logic [15:0] tavg_q;
  logic avg_valid_q;
  logic signed [12:0] avg_diff;
  logic [11:0] avg_next;
  logic [22:0] temp_cnt_q;
  logic [8:0][11:0] upper_q;
  logic [8:0][11:0] lower_q;
  logic [8:0][11:0] hyst_q;

  // command reset clears all registers except the pin filter, edge detect, bus busy flag and serial engine
  assign rst = RST_IN | soft_rst_q;

  // ----------------------------------------
  // pin conditioning
  // ----------------------------------------
  glitch_filter u_filter (
    .clk_in(MCLK_IN),
    .rst_in(RST_IN),
    .raw_in({SCL_IN, SDA_IN}),
    .clean_out(clean)
  );

  // previous filtered levels for edge and condition detect
  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_prev_q <= clean[1];
      sda_prev_q <= clean[0];
    end
  end

  assign scl_rise = clean[1] & ~scl_prev_q;
  assign scl_fall = ~clean[1] & scl_prev_q;
  assign start_cond = clean[1] & scl_prev_q & sda_prev_q & ~clean[0];
  assign stop_cond = clean[1] & scl_prev_q & ~sda_prev_q & clean[0];

  // bus busy between start and stop
  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      bus_active_q <= 1'b0;
    end else if (start_cond) begin
      bus_active_q <= 1'b1;
    end else if (stop_cond) begin
      bus_active_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // serial slave engine
  // ----------------------------------------
  // bits sampled on clock rise, data driven after clock fall
  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      state_q <= monitor_pkg::ST_IDLE;
      bit_cnt_q <= 4'h0;
      ack_phase_q <= 1'b0;
      rd_mode_q <= 1'b0;
      master_nack_q <= 1'b0;
      rx_q <= 8'h00;
      tx_q <= 8'h00;
      ptr_q <= 8'h00;
      wr_hi_q <= 8'h00;
      rd_word_q <= 16'h0000;
      SDA_OE_OUT <= 1'b0;
    end else if (start_cond) begin
      state_q <= monitor_pkg::ST_ADDR;
      bit_cnt_q <= 4'h0;
      ack_phase_q <= 1'b0;
      SDA_OE_OUT <= 1'b0;
    end else if (stop_cond) begin
      state_q <= monitor_pkg::ST_IDLE;
      ack_phase_q <= 1'b0;
      SDA_OE_OUT <= 1'b0;
    end else if (scl_rise) begin
      if (!ack_phase_q && bit_cnt_q < 4'h8) begin
        rx_q <= {rx_q[6:0], clean[0]};
        bit_cnt_q <= bit_cnt_q + 4'h1;
      end else if (ack_phase_q) begin
        master_nack_q <= clean[0];
      end
    end else if (scl_fall && state_q != monitor_pkg::ST_IDLE) begin
      if (!ack_phase_q && bit_cnt_q == 4'h8) begin
        // byte complete: answer in the ninth bit slot
        ack_phase_q <= 1'b1;
        case (state_q)
          monitor_pkg::ST_ADDR: begin
            if (rx_q[7:1] == monitor_pkg::DEV_ADDR) begin
              SDA_OE_OUT <= 1'b1;
              rd_mode_q <= rx_q[0];
            end else begin
              state_q <= monitor_pkg::ST_IDLE;
            end
          end
          monitor_pkg::ST_PTR: begin
            ptr_q <= rx_q;
            SDA_OE_OUT <= 1'b1;
          end
          monitor_pkg::ST_WHI: begin
            wr_hi_q <= rx_q;
            SDA_OE_OUT <= 1'b1;
          end
          monitor_pkg::ST_WLO: begin
            SDA_OE_OUT <= 1'b1;
          end
          monitor_pkg::ST_READ: begin
            SDA_OE_OUT <= 1'b0;
          end
          default: begin
            SDA_OE_OUT <= 1'b0;
          end
        endcase
      end else if (ack_phase_q) begin
        // ninth slot over: move to next byte
        ack_phase_q <= 1'b0;
        bit_cnt_q <= 4'h0;
        SDA_OE_OUT <= 1'b0;
        case (state_q)
          monitor_pkg::ST_ADDR: begin
            if (rd_mode_q) begin
              state_q <= monitor_pkg::ST_READ;
              rd_word_q <= rd_mux;
              tx_q <= rd_mux[15:8];
              SDA_OE_OUT <= ~rd_mux[15];
            end else begin
              state_q <= monitor_pkg::ST_PTR;
            end
          end
          monitor_pkg::ST_PTR: state_q <= monitor_pkg::ST_WHI;
          monitor_pkg::ST_WHI: state_q <= monitor_pkg::ST_WLO;
          monitor_pkg::ST_WLO: state_q <= monitor_pkg::ST_WHI;
          monitor_pkg::ST_READ: begin
            if (master_nack_q) begin
              state_q <= monitor_pkg::ST_IDLE;
            end else if (rd_mode_q) begin // low byte of the latched word still owed
              tx_q <= rd_word_q[7:0];
              SDA_OE_OUT <= ~rd_word_q[7];
              rd_mode_q <= 1'b0;
            end else begin
              rd_word_q <= rd_mux;
              tx_q <= rd_mux[15:8];
              SDA_OE_OUT <= ~rd_mux[15];
              rd_mode_q <= 1'b1;
            end
          end
          default: state_q <= monitor_pkg::ST_IDLE;
        endcase
      end else if (state_q == monitor_pkg::ST_READ) begin
        // next data bit of the byte
        tx_q <= {tx_q[6:0], 1'b0};
        SDA_OE_OUT <= ~tx_q[6];
      end
    end
  end

  // open-drain data pin only ever pulls low
  always_ff @(posedge MCLK_IN) begin
    SDA_OUT <= 1'b0;
  end

  // second data byte completes a register write
  assign wr_stb = scl_fall && !ack_phase_q && (bit_cnt_q == 4'h8)
    && (state_q == monitor_pkg::ST_WLO);
  assign wr_data = {wr_hi_q, rx_q};

  // ----------------------------------------
  // command register
  // ----------------------------------------
  always_ff @(posedge MCLK_IN) begin
    if (rst) begin
      cmd_q <= monitor_pkg::CMD_RESET;
    end else if (wr_stb && ptr_q == monitor_pkg::PTR_CMD) begin
      cmd_q <= wr_data & ~(16'h0001 << monitor_pkg::CMD_RST);
    end
  end

  // reset bit acts once and reads back as zero
  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      soft_rst_q <= 1'b0;
    end else begin
      soft_rst_q <= wr_stb && (ptr_q == monitor_pkg::PTR_CMD)
        && wr_data[monitor_pkg::CMD_RST];
    end
  end

  // ----------------------------------------
  // limit and hysteresis registers
  // ----------------------------------------
  genvar c;
  generate
    for (c = 0; c < monitor_pkg::NUM_CH; c++) begin : g_lim
      localparam logic [7:0] BASE = 8'(monitor_pkg::PTR_LIM_BASE
        + monitor_pkg::LIM_STRIDE * c);
      localparam logic [11:0] UP_RST = (c == monitor_pkg::NUM_CH - 1)
        ? monitor_pkg::TUP_RESET : monitor_pkg::VUP_RESET;
      localparam logic [11:0] LO_RST = (c == monitor_pkg::NUM_CH - 1)
        ? monitor_pkg::TLO_RESET : monitor_pkg::VLO_RESET;
      // three writable words per channel, upper nibble dropped
      always_ff @(posedge MCLK_IN) begin
        if (rst) begin
          upper_q[c] <= UP_RST;
          lower_q[c] <= LO_RST;
          hyst_q[c] <= monitor_pkg::HYS_RESET;
        end else if (wr_stb) begin
          if (ptr_q == BASE) begin
            upper_q[c] <= wr_data[11:0];
          end
          if (ptr_q == BASE + 8'h01) begin
            lower_q[c] <= wr_data[11:0];
          end
          if (ptr_q == BASE + 8'h02) begin
            hyst_q[c] <= wr_data[11:0];
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // result registers
  // ----------------------------------------
  // running average, step of one eighth of the error
  assign avg_diff = 13'(signed'(CONV_DATA_IN)) - 13'(signed'(tavg_q[11:0]));
  assign avg_next = tavg_q[11:0] + 12'(avg_diff >>> monitor_pkg::AVG_SHIFT);

  // results of tags 0..8 stored with tag whenever the core delivers one; other tags dropped
  always_ff @(posedge MCLK_IN) begin
    if (rst) begin
      vres_q <= monitor_pkg::RES_RESET;
      tres_q <= monitor_pkg::RES_RESET;
      tavg_q <= monitor_pkg::RES_RESET;
      avg_valid_q <= 1'b0;
    end else if (CONV_VALID_IN) begin
      if (CONV_TAG_IN < monitor_pkg::TAG_TEMP) begin
        vres_q <= {CONV_TAG_IN, CONV_DATA_IN};
      end else if (CONV_TAG_IN == monitor_pkg::TAG_TEMP) begin
        tres_q <= {monitor_pkg::TAG_TEMP, CONV_DATA_IN};
        avg_valid_q <= 1'b1;
        if (avg_valid_q) begin
          tavg_q <= {monitor_pkg::TAG_TAVG, avg_next};
        end else begin
          tavg_q <= {monitor_pkg::TAG_TAVG, CONV_DATA_IN};
        end
      end
    end
  end

  // ----------------------------------------
  // temperature conversion pacing
  // ----------------------------------------
  always_ff @(posedge MCLK_IN) begin
    if (rst) begin
      temp_cnt_q <= 23'h000000;
      TEMP_REQ_OUT <= 1'b0;
    end else if (temp_cnt_q == 23'(TEMP_CYC - 1)) begin
      temp_cnt_q <= 23'h000000;
      TEMP_REQ_OUT <= 1'b1;
    end else begin
      temp_cnt_q <= temp_cnt_q + 23'h000001;
      TEMP_REQ_OUT <= 1'b0;
    end
  end

  // ----------------------------------------
  // read data select
  // ----------------------------------------
  always_comb begin
    rd_mux = 16'h0000;
    case (ptr_q)
      monitor_pkg::PTR_CMD: rd_mux = cmd_q;
      monitor_pkg::PTR_VRES: rd_mux = vres_q;
      monitor_pkg::PTR_TRES: rd_mux = tres_q;
      monitor_pkg::PTR_TAVG: rd_mux = tavg_q;
      default: begin
        for (int k = 0; k < monitor_pkg::NUM_CH; k++) begin
          if (ptr_q == 8'(monitor_pkg::PTR_LIM_BASE + monitor_pkg::LIM_STRIDE * k)) begin
            rd_mux = {4'h0, upper_q[k]};
          end
          if (ptr_q == 8'(monitor_pkg::PTR_LIM_BASE + monitor_pkg::LIM_STRIDE * k + 1)) begin
            rd_mux = {4'h0, lower_q[k]};
          end
          if (ptr_q == 8'(monitor_pkg::PTR_LIM_BASE + monitor_pkg::LIM_STRIDE * k + 2)) begin
            rd_mux = {4'h0, hyst_q[k]};
          end
        end
      end
    endcase
  end

  // ----------------------------------------
  // limit checking
  // ----------------------------------------
  assign mon.conv_valid = CONV_VALID_IN;
  assign mon.conv_tag = CONV_TAG_IN;
  assign mon.conv_data = CONV_DATA_IN;
  assign mon.upper = upper_q;
  assign mon.lower = lower_q;
  assign mon.hyst = hyst_q;
  assign mon.clear = cmd_q[monitor_pkg::CMD_CLR];

  limit_checker u_check (
    .clk_in(MCLK_IN),
    .rst_in(rst),
    .mon(mon.check)
  );

  // ----------------------------------------
  // core control and alarm outputs
  // ----------------------------------------
  always_ff @(posedge MCLK_IN) begin
    if (rst) begin
      HOLD_TRIALS_OUT <= 1'b0;
      ALERT_OUT <= 1'b0;
    end else begin
      HOLD_TRIALS_OUT <= cmd_q[monitor_pkg::CMD_QUIET] & bus_active_q;
      ALERT_OUT <= (|mon.alarm) ^ cmd_q[monitor_pkg::CMD_POL];
    end
  end

  // configuration straight from command register flops
  assign CHAN_SEL_OUT = cmd_q[15:monitor_pkg::CMD_SEL_LSB];
  assign AUTOCYCLE_OUT = cmd_q[monitor_pkg::CMD_AUTO];
  assign EXT_REF_OUT = cmd_q[monitor_pkg::CMD_EXTREF];
endmodule // adc_result_limit_monitor

// File: sim/monitor_chk.sv
// port assertions of the result and limit monitor
`timescale 1ns/1ns
module monitor_chk #(
  parameter int TEMP_CYC = 200
) (
  // clock, reset and bus pins
  input wire logic MCLK_IN,
  input wire logic RST_IN,
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  input wire logic SDA_OE_OUT,
  // converter and alarm
  input wire logic CONV_VALID_IN,
  input wire logic TEMP_REQ_OUT,
  input wire logic HOLD_TRIALS_OUT,
  input wire logic ALERT_OUT
);
  int idle_q = 0;
  int gap_q = 0;
  logic seen_q = 1'b0;
  default clocking @(posedge MCLK_IN); endclocking
  default disable iff (RST_IN);
  // idle span of the bus
  always_ff @(posedge MCLK_IN) begin
    idle_q <= (SCL_IN && SDA_IN) ? idle_q + 1 : 0;
  end
  // spacing of temperature requests
  always_ff @(posedge MCLK_IN) begin
    gap_q <= (RST_IN || TEMP_REQ_OUT) ? 0 : gap_q + 1;
    seen_q <= !RST_IN && (seen_q || TEMP_REQ_OUT);
  end
  // bus idle long enough for a stop to be seen
  sequence quiet_bus_s;
    (SCL_IN && SDA_IN)[*8] ##4 1'b1;
  endsequence
  reset_state_a: assert property ($fell(RST_IN) |-> !ALERT_OUT && !HOLD_TRIALS_OUT)
    else $error("alert or hold set after reset");
  reset_pins_a: assert property ($fell(RST_IN) |-> !SDA_OE_OUT && !TEMP_REQ_OUT)
    else $error("bus drive or request set after reset");
  hold_idle_a: assert property (quiet_bus_s |-> !HOLD_TRIALS_OUT)
    else $error("hold asserted on an idle bus");
  oe_idle_a: assert property (SDA_OE_OUT |-> idle_q < 20)
    else $error("data line driven on an idle bus");
  req_pulse_a: assert property (TEMP_REQ_OUT |=> !TEMP_REQ_OUT)
    else $error("temperature request longer than one cycle");
  req_period_a: assert property (TEMP_REQ_OUT && seen_q |-> gap_q == TEMP_CYC - 1)
    else $error("temperature request period wrong");
  req_gap_a: assert property (seen_q |-> gap_q < TEMP_CYC)
    else $error("temperature request missing");
  alert_cause_a: assert property ($changed(ALERT_OUT) |-> $past(CONV_VALID_IN, 2) || idle_q < 50)
    else $error("alert moved without a result or command");
endmodule // monitor_chk
bind adc_result_limit_monitor monitor_chk #(.TEMP_CYC(TEMP_CYC)) chk (
  .MCLK_IN(MCLK_IN), .RST_IN(RST_IN), .SCL_IN(SCL_IN), .SDA_IN(SDA_IN),
  .SDA_OE_OUT(SDA_OE_OUT), .CONV_VALID_IN(CONV_VALID_IN), .TEMP_REQ_OUT(TEMP_REQ_OUT),
  .HOLD_TRIALS_OUT(HOLD_TRIALS_OUT), .ALERT_OUT(ALERT_OUT));

// File: sim/i2c_master_model.sv
// two-wire bus master reading and writing the monitor registers
`timescale 1ns/1ns
module i2c_master_model (
  // bus lines, released high
  output logic scl_out,
  output logic sda_out,
  input wire logic sda_in
);
  // idle bus, clock stands still
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end
  // long low phase covers the slave's data hold
  task automatic bit_io(input logic b, output logic s);
    sda_out = b;
    #62;
    scl_out = 1'b1;
    #63;
    s = sda_in;
    scl_out = 1'b0;
    #63;
  endtask
  task automatic send(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], s);
    end
    bit_io(1'b1, s);
    ack = ~s;
  endtask
  task automatic recv(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      b[i] = s;
    end
    bit_io(last, s);
  endtask
  task automatic start();
    sda_out = 1'b0;
    #63;
    scl_out = 1'b0;
    #63;
  endtask
  task automatic stop();
    sda_out = 1'b0;
    #62;
    scl_out = 1'b1;
    #63;
    sda_out = 1'b1;
    #120;
  endtask
  task automatic reg_wr(input logic [7:0] p, input logic [15:0] d, output logic ok);
    logic a0, a1, a2, a3;
    start();
    send({monitor_pkg::DEV_ADDR, 1'b0}, a0);
    send(p, a1);
    send(d[15:8], a2);
    send(d[7:0], a3);
    stop();
    ok = a0 & a1 & a2 & a3;
  endtask
  task automatic reg_rd(input logic [7:0] p, output logic [15:0] d);
    logic a;
    start();
    send({monitor_pkg::DEV_ADDR, 1'b0}, a);
    send(p, a);
    stop();
    start();
    send({monitor_pkg::DEV_ADDR, 1'b1}, a);
    recv(1'b0, d[15:8]);
    recv(1'b1, d[7:0]);
    stop();
  endtask
  // short low pulse on the data line
  task automatic glitch();
    sda_out = 1'b0;
    #30;
    sda_out = 1'b1;
  endtask
endmodule // i2c_master_model

// File: sim/tb_adc_result_limit_monitor.sv
// self-checking bench of the result and limit monitor
`timescale 1ns/1ns
module tb_adc_result_limit_monitor;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cv = 1'b0;
  logic [3:0] ctag = 4'h0;
  logic [11:0] cdat = 12'h000;
  logic scl, sda_m, sda_oe, treq, hold, alert;
  logic [8:0] csel;
  logic acyc, eref, sda_o;
  wire logic sda_bus;
  int miscompares = 0;
  int n_checks = 0;
  // open-drain data line with pull-up
  assign sda_bus = sda_m & (sda_o | ~sda_oe);
  // 100 MHz clock
  always #5 clk = ~clk;
  adc_result_limit_monitor #(.TEMP_CYC(200)) dut (
    .MCLK_IN(clk), .RST_IN(rst), .SCL_IN(scl), .SDA_IN(sda_bus), .SDA_OUT(sda_o),
    .SDA_OE_OUT(sda_oe), .CONV_VALID_IN(cv), .CONV_TAG_IN(ctag), .CONV_DATA_IN(cdat),
    .TEMP_REQ_OUT(treq), .HOLD_TRIALS_OUT(hold), .CHAN_SEL_OUT(csel), .AUTOCYCLE_OUT(acyc),
    .EXT_REF_OUT(eref), .ALERT_OUT(alert));
  i2c_master_model m (.scl_out(scl), .sda_out(sda_m), .sda_in(sda_bus));
  // ----------------------------------------
  // compares and bus access
  // ----------------------------------------
  task automatic chk_w(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_b(input string nm, input logic e, input logic g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] p, input logic [15:0] d);
    logic ok;
    m.reg_wr(p, d, ok);
    chk_b("write ack", 1'b1, ok);
  endtask
  task automatic rd(input logic [7:0] p, input logic [15:0] e);
    logic [15:0] d;
    m.reg_rd(p, d);
    chk_w("read word", e, d);
  endtask
  task automatic conv(input logic [3:0] t, input logic [11:0] v, input logic e);
    @(posedge clk);
    cv <= 1'b1;
    ctag <= t;
    cdat <= v;
    @(posedge clk);
    cv <= 1'b0;
    repeat (3) @(posedge clk);
    chk_b("alert", e, alert);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    chk_b("alert", 1'b0, alert);
    chk_b("hold", 1'b0, hold);
    rd(8'h04, 16'h0fff);
    rd(8'h05, 16'h0000);
    rd(8'h1c, 16'h07ff);
    rd(8'h1d, 16'h0800);
    rd(8'h06, 16'h0000);
  endtask
  task automatic t_vres();
    for (int t = 0; t < 8; t++) begin
      conv(t[3:0], 12'h800 + 12'(t), 1'b0);
      rd(8'h01, {t[3:0], 12'h800 + 12'(t)});
    end
    wr(8'h01, 16'h0123);
    rd(8'h01, 16'h7807);
  endtask
  task automatic t_temp();
    conv(4'h8, 12'hf80, 1'b0);
    rd(8'h02, 16'h8f80);
    rd(8'h03, 16'h9f80);
    conv(4'h8, 12'h008, 1'b0);
    rd(8'h03, 16'h9f91);
  endtask
  task automatic t_limits();
    wr(8'h07, 16'hf200);
    rd(8'h07, 16'h0200);
    wr(8'h04, 16'h0100);
    wr(8'h06, 16'h0010);
    rd(8'h06, 16'h0010);
    conv(4'h0, 12'h100, 1'b0);
    conv(4'h0, 12'h101, 1'b1);
    conv(4'h0, 12'h0f1, 1'b1);
    conv(4'h0, 12'h0f0, 1'b0);
    wr(8'h05, 16'h0050);
    conv(4'h0, 12'h04f, 1'b1);
    conv(4'h0, 12'h05f, 1'b1);
    conv(4'h0, 12'h060, 1'b0);
    wr(8'h1c, 16'h0010);
    conv(4'h8, 12'h020, 1'b1);
    conv(4'h0, 12'h04f, 1'b1);
    conv(4'h8, 12'hf80, 1'b1);
    conv(4'h0, 12'h080, 1'b0);
  endtask
  task automatic t_pol();
    wr(8'h00, 16'h8019);
    chk_b("alert", 1'b1, alert);
    chk_w("config", 16'h0807, {4'h0, csel, acyc, eref, alert});
    conv(4'h0, 12'h101, 1'b0);
    wr(8'h00, 16'h000c);
    chk_b("alert", 1'b1, alert);
    wr(8'h00, 16'h0008);
    conv(4'h0, 12'h102, 1'b0);
    wr(8'h00, 16'h0000);
    chk_b("alert", 1'b1, alert);
    conv(4'h0, 12'h0f0, 1'b0);
  endtask
  task automatic t_quiet();
    logic [15:0] d;
    logic busy;
    wr(8'h00, 16'h0020);
    fork
      m.reg_rd(8'h00, d);
      begin
        repeat (100) @(posedge clk);
        busy = hold;
      end
    join
    chk_b("hold busy", 1'b1, busy);
    chk_w("command", 16'h0020, d);
    busy = 1'b0;
    m.glitch();
    repeat (20) begin
      @(posedge clk);
      busy = busy | hold;
    end
    chk_b("hold glitch", 1'b0, busy);
  endtask
  // reset, then the scenarios in turn
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (10) @(posedge clk);
    t_reset();
    t_vres();
    t_temp();
    t_limits();
    t_pol();
    t_quiet();
    end_sim();
  end
  // watchdog against a hung bus
  initial begin
    #800000;
    miscompares++;
    end_sim();
  end
endmodule // tb_adc_result_limit_monitor
